// ### core/tcc_defs.svh
// Constants of the temperature controller command handler
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH
// Register offsets (byte addresses)
`define TCC_OFS_CMD      8'h00
`define TCC_OFS_RESP     8'h04
`define TCC_OFS_ISTAT    8'h08
`define TCC_OFS_IMASK    8'h0C
`define TCC_OFS_DSTATE   8'h10
`define TCC_OFS_ERRW     8'h14
// Command word fields
`define TCC_CMD_PAR_MSB  15
`define TCC_CMD_CODE_LSB 16
`define TCC_CMD_CODE_MSB 24
`define TCC_CMD_KIND_LSB 25
`define TCC_CMD_KIND_MSB 27
// Response word fields
`define TCC_RESP_BUSY    16
`define TCC_RESP_REJ     17
// Command codes
`define TCC_CODE_VERSION 9'h06A
`define TCC_CODE_CHIPT   9'h06B
`define TCC_CODE_SENS1   9'h078
`define TCC_CODE_SENS2   9'h079
`define TCC_CODE_SENS3   9'h07A
`define TCC_CODE_KIND    9'h0C8
`define TCC_CODE_DSTATE  9'h0C9
`define TCC_CODE_ERRW    9'h0CA
`define TCC_CODE_CFG0    9'h12C
`define TCC_CODE_CFGN    9'h147
// Configuration entry indices
`define TCC_IDX_IL       5'h09
`define TCC_IDX_DZ_MIN   5'h17
`define TCC_IDX_DZ_MAX   5'h18
`define TCC_IDX_SENSOR   5'h1A
`define TCC_IDX_MODE     5'h1B
`define TCC_IDX_LAST     5'h1B
// Reset values and scaling
`define TCC_IL_RST       16'h0019
`define TCC_IL_SCALE     16'h000A
`define TCC_DZ_RST       16'hFC19
`define TCC_VER_MAIN     16'h0064
`define TCC_VER_SUB      16'h0000
`define TCC_VER_SCALE    16'h0064
`define TCC_DEV_KIND     16'h0A51
// Sensor kinds and controller modes
`define TCC_SENS_PT100   2'h0
`define TCC_SENS_PT1000  2'h1
`define TCC_SENS_SPECIAL 2'h2
`define TCC_MODE_HEATER  16'h0001
// Device-state bit positions
`define TCC_ST_AUX_OUT   0
`define TCC_ST_AUX_IN    1
`define TCC_ST_FAN       2
`define TCC_ST_DZ_LO     3
`define TCC_ST_DZ_IN     4
`define TCC_ST_DZ_HI     5
// Error word bit of an unimplemented request
`define TCC_ERR_NOT_IMPL 12
// Interrupt status bits
`define TCC_IRQ_DONE     0
`define TCC_IRQ_REJ      1
`define TCC_IRQ_ERR      2
`define TCC_IRQ_LOAD     3
`endif

// ### core/tcc_pkg.sv
// Types of the temperature controller command handler
package tcc_pkg;
   typedef enum logic [2:0] {
      kind_read, kind_write, kind_read_nv, kind_write_nv, kind_update
   } tcc_kind_t;
   typedef enum logic [2:0] {
      s_idle, s_load_rd, s_load_wr, s_cfg_rd, s_cfg_ans
   } tcc_state_t;
endpackage : tcc_pkg

// ### core/tcc_cfg_mem.sv
// Configuration copy store, 32 words of 16 bits, registered read
`timescale 1ns/1ns
module tcc_cfg_mem (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   // Write port
   input  wire logic        we,
   input  wire logic [4:0]  waddr,
   input  wire logic [15:0] wdata,
   // Read port
   input  wire logic [4:0]  raddr,
   output logic      [15:0] rdata_q
);
   logic [15:0] mem_q [0:31];

   // Array has no reset: contents survive a system reset
   always_ff @(posedge clk_sys) begin
      if (we) begin
         mem_q[waddr] <= wdata;
      end
   end

   // Read data one cycle after the address
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_q <= 16'h0000;
      end else begin
         rdata_q <= mem_q[raddr];
      end
   end
endmodule : tcc_cfg_mem

// ### core/tcc_irq.sv
// Sticky interrupt status with mask and level output
`timescale 1ns/1ns
module tcc_irq (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       sys_rst,
   // Events and software access
   input  wire logic [3:0] ev,
   input  wire logic       wr_stat,
   input  wire logic       wr_mask,
   input  wire logic [3:0] wdata,
   // State
   output logic      [3:0] stat_q,
   output logic      [3:0] mask_q,
   output logic            irq_q
);
   logic [3:0] stat_d;

   // Write one clears; a new event in the same cycle wins
   always_comb begin
      stat_d = (stat_q & ~(wr_stat ? wdata : 4'h0)) | ev;
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         stat_q <= 4'h0;
         mask_q <= 4'h0;
         irq_q  <= 1'b0;
      end else begin
         stat_q <= stat_d;
         irq_q  <= |(stat_d & (wr_mask ? wdata : mask_q));
         if (wr_mask) begin
            mask_q <= wdata;
         end
      end
   end
endmodule : tcc_irq

// ### core/tcc_cmd.sv
// Command handler of the temperature controller
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ns
`include "tcc_defs.svh"
module tcc_cmd (
   // Clock and reset
   input  wire logic               clk_sys,
   input  wire logic               sys_rst,
   // Register port
   input  wire logic [7:0]         reg_addr,
   input  wire logic [31:0]        reg_wdata,
   input  wire logic               reg_wr,
   input  wire logic               reg_rd,
   output logic      [31:0]        reg_rdata,
   output logic                    irq,
   // Asynchronous pins
   input  wire logic               fan_run_pin,
   input  wire logic               aux_in_pin,
   input  wire logic               aux_out_pin,
   input  wire logic [15:0]        err_src_pin,
   // Measured values from the same clock domain
   input  wire logic signed [15:0] sensor1_val,
   input  wire logic signed [15:0] sensor2_val,
   input  wire logic signed [15:0] sensor3_val,
   input  wire logic [15:0]        chip_temp,
   // Configuration outputs
   output logic                    thermoelectric_mode,
   output logic                    heater_only_mode,
   output logic [1:0]              sensor_kind_sel,
   output logic [13:0]             integration_limit
);
   import tcc_pkg::*;
   localparam int NSYNC = 19;
   tcc_state_t         state_q;
   tcc_kind_t          kind_q;
   logic [15:0]        par_q;
   logic [8:0]         code_q;
   logic               go_q;
   logic [4:0]         cnt_q;
   logic [15:0]        resp_q;
   logic               rej_q;
   logic               not_impl_q;
   logic [15:0]        dstate_q;
   logic [15:0]        err_q;
   logic [15:0]        err_prev_q;
   logic [31:0]        rdata_q;
   logic [NSYNC-1:0]   meta_q;
   logic [NSYNC-1:0]   sync_q;
   logic [NSYNC-1:0]   pins;
   logic signed [15:0] dz_min_q;
   logic signed [15:0] dz_max_q;
   logic               mode_heat_q;
   logic [1:0]         sens_q;
   logic [13:0]        il_q;
   logic [3:0]         ev;
   logic [3:0]         istat;
   logic [3:0]         imask;
   logic               cfg_hit;
   logic [4:0]         idx;
   logic [8:0]         cfg_off;
   logic               fix_hit;
   logic [15:0]        fix_val;
   logic               busy;
   logic               cmd_wr;
   logic               work_we;
   logic [4:0]         work_waddr;
   logic [15:0]        work_wdata;
   logic [15:0]        work_rdata;
   logic               nv_we;
   logic [4:0]         nv_raddr;
   logic [15:0]        nv_rdata;
   logic               ev_done;
   logic               ev_rej;
   logic               ev_load;
   logic [15:0]        err_now;

   assign pins = {fan_run_pin, aux_in_pin, aux_out_pin, err_src_pin};

   // Two-stage synchroniser per pin bit
   for (genvar i = 0; i < NSYNC; i++) begin : g_sync
      always_ff @(posedge clk_sys or posedge sys_rst) begin
         if (sys_rst) begin
            meta_q[i] <= 1'b0;
            sync_q[i] <= 1'b0;
         end else begin
            meta_q[i] <= pins[i];
            sync_q[i] <= meta_q[i];
         end
      end
   end

   // Command decode
   always_comb begin
      cfg_off = code_q - `TCC_CODE_CFG0;
      idx     = cfg_off[4:0];
      cfg_hit = (code_q >= `TCC_CODE_CFG0) && (code_q <= `TCC_CODE_CFGN);
      busy    = (state_q != s_idle) || go_q;
      cmd_wr  = reg_wr && (reg_addr == `TCC_OFS_CMD);
   end

   // Answers of the fixed read codes; the parameter is not looked at
   always_comb begin
      fix_hit = 1'b1;
      fix_val = 16'h0000;
      case (code_q)
         `TCC_CODE_VERSION: fix_val = 16'(`TCC_VER_MAIN * `TCC_VER_SCALE + `TCC_VER_SUB);
         `TCC_CODE_CHIPT:   fix_val = chip_temp;
         `TCC_CODE_SENS1:   fix_val = sensor1_val;
         `TCC_CODE_SENS2:   fix_val = sensor2_val;
         `TCC_CODE_SENS3:   fix_val = sensor3_val;
         `TCC_CODE_KIND:    fix_val = `TCC_DEV_KIND; // Arbitrary identity value
         `TCC_CODE_DSTATE:  fix_val = dstate_q;
         `TCC_CODE_ERRW:    fix_val = err_q;
         default:           fix_hit = 1'b0;
      endcase
   end

   // Store control: the update walk owns the working copy while it runs
   always_comb begin
      work_we    = 1'b0;
      work_waddr = idx;
      work_wdata = par_q;
      nv_we      = 1'b0;
      nv_raddr   = idx;
      if (state_q == s_load_wr) begin
         work_we    = 1'b1;
         work_waddr = cnt_q;
         work_wdata = nv_rdata;
      end else if (state_q == s_idle && go_q && cfg_hit) begin
         work_we = (kind_q == kind_write);
         nv_we   = (kind_q == kind_write_nv);
      end
      if (state_q == s_load_rd) begin
         nv_raddr = cnt_q;
      end
   end

   // Working copy, volatile
   tcc_cfg_mem u_work (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .we      (work_we),
      .waddr   (work_waddr),
      .wdata   (work_wdata),
      .raddr   (idx),
      .rdata_q (work_rdata)
   );

   // Persistent copy; its array is not cleared by reset
   tcc_cfg_mem u_nv (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .we      (nv_we),
      .waddr   (idx),
      .wdata   (par_q),
      .raddr   (nv_raddr),
      .rdata_q (nv_rdata)
   );

   // Command capture; a command written while busy is dropped and flagged
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         par_q  <= 16'h0000;
         code_q <= 9'h000;
         kind_q <= kind_read;
         go_q   <= 1'b0;
      end else if (cmd_wr && !busy) begin
         par_q  <= reg_wdata[`TCC_CMD_PAR_MSB:0];
         code_q <= reg_wdata[`TCC_CMD_CODE_MSB:`TCC_CMD_CODE_LSB];
         kind_q <= tcc_kind_t'(reg_wdata[`TCC_CMD_KIND_MSB:`TCC_CMD_KIND_LSB]);
         go_q   <= 1'b1;
      end else if (state_q == s_idle) begin
         go_q <= 1'b0;
      end
   end

   // Sequencer; reset starts with the copy of the persistent values
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= s_load_rd;
         cnt_q   <= 5'h00;
         resp_q  <= 16'h0000;
         rej_q   <= 1'b0;
         ev_done <= 1'b0;
         ev_rej  <= 1'b0;
         ev_load <= 1'b0;
      end else begin
         ev_done <= 1'b0;
         ev_rej  <= cmd_wr && busy;
         ev_load <= 1'b0;
         case (state_q)
            s_idle: begin
               if (go_q) begin
                  rej_q <= 1'b0;
                  if (kind_q == kind_update) begin
                     cnt_q   <= 5'h00;
                     state_q <= s_load_rd;
                  end else if (cfg_hit && (kind_q == kind_read || kind_q == kind_read_nv)) begin
                     state_q <= s_cfg_rd;
                  end else if (cfg_hit && (kind_q == kind_write || kind_q == kind_write_nv)) begin
                     resp_q  <= par_q;
                     ev_done <= 1'b1;
                  end else if (fix_hit && kind_q == kind_read) begin
                     resp_q  <= fix_val;
                     ev_done <= 1'b1;
                  end else begin
                     rej_q  <= 1'b1;
                     ev_rej <= 1'b1;
                  end
               end
            end
            s_load_rd: begin
               state_q <= s_load_wr;
            end
            s_load_wr: begin
               if (cnt_q == `TCC_IDX_LAST) begin
                  state_q <= s_idle;
                  ev_load <= 1'b1;
               end else begin
                  cnt_q   <= cnt_q + 5'h01;
                  state_q <= s_load_rd;
               end
            end
            s_cfg_rd: begin
               state_q <= s_cfg_ans;
            end
            s_cfg_ans: begin
               resp_q  <= (kind_q == kind_read_nv) ? nv_rdata : work_rdata;
               ev_done <= 1'b1;
               state_q <= s_idle;
            end
            default: begin
               state_q <= s_idle;
            end
         endcase
      end
   end

   // Working-copy fields that steer the controller, caught on each write
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         il_q        <= 14'(`TCC_IL_RST * `TCC_IL_SCALE);
         mode_heat_q <= 1'b0;
         sens_q      <= `TCC_SENS_PT100;
         dz_min_q    <= `TCC_DZ_RST;
         dz_max_q    <= `TCC_DZ_RST;
      end else if (work_we) begin
         case (work_waddr)
            `TCC_IDX_IL:     il_q <= 14'(work_wdata * `TCC_IL_SCALE);
            `TCC_IDX_MODE:   mode_heat_q <= (work_wdata == `TCC_MODE_HEATER);
            `TCC_IDX_SENSOR: begin
               // Codes above the special sensor fall back to it
               if (work_wdata > 16'(`TCC_SENS_SPECIAL)) begin
                  sens_q <= `TCC_SENS_SPECIAL;
               end else begin
                  sens_q <= work_wdata[1:0];
               end
            end
            `TCC_IDX_DZ_MIN: dz_min_q <= work_wdata;
            `TCC_IDX_DZ_MAX: dz_max_q <= work_wdata;
            default: begin
            end
         endcase
      end
   end

   // Configuration outputs, registered
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         thermoelectric_mode <= 1'b1;
         heater_only_mode    <= 1'b0;
         sensor_kind_sel     <= `TCC_SENS_PT100;
         integration_limit   <= 14'h0000;
      end else begin
         thermoelectric_mode <= !mode_heat_q;
         heater_only_mode    <= mode_heat_q;
         sensor_kind_sel     <= sens_q;
         integration_limit   <= il_q;
      end
   end

   // Device-state word
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         dstate_q <= 16'h0000;
      end else begin
         dstate_q <= 16'h0000;
         dstate_q[`TCC_ST_AUX_OUT] <= !sync_q[16];
         dstate_q[`TCC_ST_AUX_IN]  <= !sync_q[17];
         dstate_q[`TCC_ST_FAN]     <= sync_q[18];
         dstate_q[`TCC_ST_DZ_LO]   <= sensor2_val < dz_min_q;
         dstate_q[`TCC_ST_DZ_IN]   <= (sensor2_val >= dz_min_q) && (sensor2_val <= dz_max_q);
         dstate_q[`TCC_ST_DZ_HI]   <= sensor2_val > dz_max_q;
      end
   end

   // Error word: pin bit n reports error bit n except bit 12, the unimplemented flag; MSB is bit 15
   always_comb begin
      err_now = sync_q[15:0];
      err_now[3:0]   = sync_q[3:0];
      err_now[6:4]   = sync_q[6:4];
      err_now[8:7]   = sync_q[8:7];
      err_now[11:9]  = sync_q[11:9];
      err_now[`TCC_ERR_NOT_IMPL] = not_impl_q;
   end

   // Unimplemented flag: set by a refused command, cleared by reading the word
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         not_impl_q <= 1'b0;
         err_q      <= 16'h0000;
         err_prev_q <= 16'h0000;
      end else begin
         // Same refusal as the sequencer: unknown code or a kind the code does not take
         if (state_q == s_idle && go_q && kind_q != kind_update &&
             !(cfg_hit && kind_q < kind_update) && !(fix_hit && kind_q == kind_read)) begin
            not_impl_q <= 1'b1;
         end else if (reg_rd && reg_addr == `TCC_OFS_ERRW) begin
            not_impl_q <= 1'b0;
         end
         err_q      <= err_now;
         err_prev_q <= err_q;
      end
   end
   assign ev = {ev_load, |(err_q & ~err_prev_q), ev_rej, ev_done};

   // Interrupt status and mask
   tcc_irq u_irq (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .ev      (ev),
      .wr_stat (reg_wr && reg_addr == `TCC_OFS_ISTAT),
      .wr_mask (reg_wr && reg_addr == `TCC_OFS_IMASK),
      .wdata   (reg_wdata[3:0]),
      .stat_q  (istat),
      .mask_q  (imask),
      .irq_q   (irq)
   );

   // Read data stand for one cycle only; unmapped offsets read zero
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         rdata_q <= 32'h0000_0000;
         if (reg_rd) begin
            case (reg_addr)
               `TCC_OFS_CMD:    rdata_q <= {4'h0, 3'(kind_q), code_q, par_q};
               `TCC_OFS_RESP:   rdata_q <= {14'h0000, rej_q, busy, resp_q};
               `TCC_OFS_ISTAT:  rdata_q <= {28'h0000000, istat};
               `TCC_OFS_IMASK:  rdata_q <= {28'h0000000, imask};
               `TCC_OFS_DSTATE: rdata_q <= {16'h0000, dstate_q};
               `TCC_OFS_ERRW:   rdata_q <= {16'h0000, err_q};
               default:         rdata_q <= 32'h0000_0000;
            endcase
         end
      end
   end
   assign reg_rdata = rdata_q;
endmodule : tcc_cmd

// ### dv/tcc_host_model.sv
// Host model that drives the register port of the command handler
`timescale 1ns/1ns
`include "tcc_defs.svh"
module tcc_host_model (
   // Clock
   input  wire logic        clk_sys,
   // Register port towards the handler
   output logic      [7:0]  reg_addr,
   output logic      [31:0] reg_wdata,
   output logic             reg_wr,
   output logic             reg_rd,
   input  wire logic [31:0] reg_rdata
);
   int nv_writes;

   // Bus idle from power on
   initial begin
      reg_addr  = 8'h00;
      reg_wdata = 32'h0000_0000;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      nv_writes = 0;
   end

   // One write cycle; released lines show the inverse so stale values never pass
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
      reg_addr  <= ~a;
      reg_wdata <= ~d;
   endtask : wr

   // One read cycle; data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      reg_addr <= ~a;
      #1;
      d = reg_rdata;
   endtask : rd

   // Codes come from the caller and are not checked; both read kinds go out with parameter 0
   task automatic cmd(input logic [2:0] k, input logic [8:0] c,
                      input logic [15:0] p, output logic [31:0] r);
      logic [15:0] par;
      par = (k == 3'h0 || k == 3'h2) ? 16'h0000 : p;
      if (k == 3'h3)
         nv_writes++;
      wr(`TCC_OFS_CMD, {4'h0, k, c, par});
      r = 32'h0001_0000;
      // Poll busy under a bound instead of guessing latencies
      for (int i = 0; i < 100 && r[16] !== 1'b0; i++) begin
         rd(`TCC_OFS_RESP, r);
      end
   endtask : cmd
endmodule : tcc_host_model

// ### dv/tcc_cmd_asserts.sv
// Port-level checks of the command handler
`timescale 1ns/1ns
`include "tcc_defs.svh"
module tcc_cmd_asserts (
   // Clock and reset
   input wire logic        clk_sys,
   input wire logic        sys_rst,
   // Register port
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic        irq,
   // Pins and configuration outputs
   input wire logic        fan_run_pin,
   input wire logic [15:0] err_src_pin,
   input wire logic        thermoelectric_mode,
   input wire logic        heater_only_mode,
   input wire logic [1:0]  sensor_kind_sel,
   input wire logic [13:0] integration_limit
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   // Pin held long enough to cross the synchroniser, then read
   sequence fan_held;
      $stable(fan_run_pin) [*6] ##0 (reg_rd && reg_addr == `TCC_OFS_DSTATE);
   endsequence
   sequence err_held;
      $stable(err_src_pin) [*6] ##0 (reg_rd && reg_addr == `TCC_OFS_ERRW);
   endsequence

   // Mode outputs are complementary; an unknown copy leaves them vacuous
   AST_MODE_TE: assert property (thermoelectric_mode |-> !heater_only_mode)
      else $error("heater mode beside thermoelectric mode");
   AST_MODE_HO: assert property (heater_only_mode |-> !thermoelectric_mode)
      else $error("thermoelectric mode beside heater mode");
   AST_SENS_CODE: assert property (sensor_kind_sel[1] |-> !sensor_kind_sel[0])
      else $error("sensor kind outside the three codes");
   AST_IL_SCALE: assert property (integration_limit != 14'h0000 |->
      integration_limit % 14'h000A == 14'h0000)
      else $error("integration limit not a multiple of ten");
   AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
      else $error("read data outside the read answer cycle");
   AST_RD_WORD: assert property (reg_rd && (reg_addr == `TCC_OFS_DSTATE ||
      reg_addr == `TCC_OFS_ERRW) |=> reg_rdata[31:16] == 16'h0000)
      else $error("state word wider than 16 bits");
   AST_FAN: assert property (fan_held |=> reg_rdata[2] == $past(fan_run_pin))
      else $error("fan bit differs from fan pin");
   AST_ERRW: assert property (err_held |=>
      (reg_rdata[15:0] & 16'hEFFF) == ($past(err_src_pin) & 16'hEFFF))
      else $error("error word differs from error sources");
   AST_IRQ_MASK: assert property (reg_wr && reg_addr == `TCC_OFS_IMASK &&
      reg_wdata[3:0] == 4'h0 |-> ##2 !irq)
      else $error("interrupt high with all sources masked");

   // Main scenarios reached
   CV_CMD: cover property (reg_wr && reg_addr == `TCC_OFS_CMD);
   CV_IRQ: cover property ($rose(irq));
   CV_HEAT: cover property (heater_only_mode);
endmodule : tcc_cmd_asserts

// ### dv/thermal_ctrl_command_set_bench.sv
// Self-checking bench of the temperature controller command handler
`timescale 1ns/1ns
`include "tcc_defs.svh"
module thermal_ctrl_command_set_bench;
   logic               clk_sys = 1'b0;
   logic               sys_rst = 1'b1;
   logic [7:0]         reg_addr;
   logic [31:0]        reg_wdata, reg_rdata, r, v;
   logic               reg_wr, reg_rd, irq, fan_run_pin, aux_in_pin, aux_out_pin;
   logic [15:0]        err_src_pin, chip_temp;
   logic signed [15:0] sensor1_val, sensor2_val, sensor3_val;
   logic               thermoelectric_mode, heater_only_mode;
   logic [1:0]         sensor_kind_sel;
   logic [13:0]        integration_limit;
   int                 failures, compares, cyc;
   int                 work [int];
   int                 pers [int];
   int                 dzv [3] = '{32'h63, 32'h64, 32'hC9};

   tcc_cmd dut_u (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .irq, .fan_run_pin, .aux_in_pin, .aux_out_pin, .err_src_pin, .sensor1_val,
      .sensor2_val, .sensor3_val, .chip_temp, .thermoelectric_mode, .heater_only_mode,
      .sensor_kind_sel, .integration_limit);
   tcc_host_model host_u (.clk_sys, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);

   // 50 MHz clock
   always #10 clk_sys = ~clk_sys;

   // Cut a hang short
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 40000) begin
         failures++;
         conclude();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic conclude();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : conclude

   // Command through the host, answer predicted by the copy model
   task automatic run(input int k, input int c, input int p);
      int e;
      e = p;
      if (k == 1)
         work[c - 32'h12C] = p;
      if (k == 3)
         pers[c - 32'h12C] = p;
      if (k == 0)
         e = work[c - 32'h12C];
      if (k == 2)
         e = pers[c - 32'h12C];
      if (k == 4)
         foreach (pers[j]) work[j] = pers[j];
      host_u.cmd(3'(k), 9'(c), 16'(p), r);
      if (k != 4)
         chk(r, {16'h0000, 16'(e)});
      repeat (3) @(posedge clk_sys);
      #1;
   endtask : run

   task automatic irq_is(input logic e);
      repeat (2) @(posedge clk_sys);
      #1;
      chk(32'(irq), 32'(e));
   endtask : irq_is

   initial begin
      {fan_run_pin, aux_in_pin, aux_out_pin} = 3'h0;
      {err_src_pin, chip_temp, sensor1_val, sensor2_val, sensor3_val} = 80'h0;
      v = $urandom(91);
      repeat (2) @(posedge clk_sys);
      sys_rst <= 1'b0;
      // Boot copy runs before the first command
      repeat (70) @(posedge clk_sys);
      host_u.cmd(3'h0, `TCC_CODE_VERSION, 16'h0000, r);
      chk(r, {16'h0000, 16'(`TCC_VER_MAIN * `TCC_VER_SCALE + `TCC_VER_SUB)});
      chk(32'(r[15:0] >= 16'h2710 && r[15:0] <= 16'h7D63), 32'h1);
      $display("test version done");
      // Persistent value acts only after the update command
      v = ($urandom % 999) + 1;
      run(1, 32'h135, 32'h19);
      run(3, 32'h135, v);
      run(0, 32'h135, 0);
      chk(32'(integration_limit), 32'hFA);
      run(2, 32'h135, 0);
      run(4, 0, 0);
      run(0, 32'h135, 0);
      chk(32'(integration_limit), v * 10);
      chk(32'(host_u.nv_writes), 32'h1);
      $display("test persistence done");
      for (int s = 0; s < 3; s++) begin
         run(1, 32'h146, s);
         chk(32'(sensor_kind_sel), s);
      end
      for (int m = 0; m < 2; m++) begin
         run(1, 32'h147, m);
         chk(32'({thermoelectric_mode, heater_only_mode}), m ? 32'h1 : 32'h2);
      end
      $display("test modes done");
      // Dead zone below, at the lower boundary, above
      run(1, 32'h143, 32'h64);
      run(1, 32'h144, 32'hC8);
      for (int t = 0; t < 3; t++) begin
         v = $urandom;
         @(posedge clk_sys);
         sensor2_val <= 16'(dzv[t]);
         {fan_run_pin, aux_in_pin, aux_out_pin} <= v[2:0];
         sensor1_val <= 16'(v[31:16]);
         sensor3_val <= 16'(v[31:20]);
         chip_temp <= v[27:12];
         repeat (6) @(posedge clk_sys);
         host_u.rd(`TCC_OFS_DSTATE, r);
         chk(r, (32'h8 << t) | {29'h0, v[2], ~v[1], ~v[0]});
      end
      host_u.cmd(3'h0, `TCC_CODE_SENS1, 16'h0000, r);
      chk(r, {16'h0000, v[31:16]});
      host_u.cmd(3'h0, `TCC_CODE_CHIPT, 16'h0000, r);
      chk(r, {16'h0000, v[27:12]});
      host_u.cmd(3'h0, `TCC_CODE_KIND, 16'h0000, r);
      chk(r, {16'h0000, `TCC_DEV_KIND});
      $display("test state word done");
      for (int t = 0; t < 4; t++) begin
         v = $urandom;
         @(posedge clk_sys);
         err_src_pin <= v[15:0];
         repeat (6) @(posedge clk_sys);
         host_u.rd(`TCC_OFS_ERRW, r);
         chk(r, {16'h0000, v[15:13], 1'b0, v[11:0]});
      end
      host_u.cmd(3'h0, `TCC_CODE_ERRW, 16'h0000, r);
      chk(r, {16'h0000, v[15:13], 1'b0, v[11:0]});
      $display("test error word done");
      // Listed codes sent with a kind that they do not take
      host_u.cmd(3'h2, `TCC_CODE_VERSION, 16'h0000, r);
      chk(r & 32'h0003_0000, 32'h0002_0000);
      host_u.cmd(3'h1, `TCC_CODE_VERSION, 16'h0001, r);
      chk(r & 32'h0003_0000, 32'h0002_0000);
      host_u.rd(`TCC_OFS_ERRW, r);
      chk(r & 32'h1000, 32'h1000);
      host_u.rd(`TCC_OFS_ERRW, r);
      chk(r & 32'h1000, 32'h0);
      $display("test refusal done");
      // Interrupt raised masked, unmasked, then cleared
      host_u.wr(`TCC_OFS_IMASK, 32'h0);
      host_u.wr(`TCC_OFS_ISTAT, 32'hF);
      host_u.cmd(3'h0, `TCC_CODE_VERSION, 16'h0000, r);
      host_u.rd(`TCC_OFS_ISTAT, r);
      chk(r, 32'h1);
      irq_is(1'b0);
      host_u.wr(`TCC_OFS_IMASK, 32'h1);
      irq_is(1'b1);
      host_u.wr(`TCC_OFS_ISTAT, 32'h1);
      irq_is(1'b0);
      host_u.rd(`TCC_OFS_IMASK, r);
      chk(r, 32'h1);
      host_u.rd(8'h20, r);
      chk(r, 32'h0);
      // Command sent while the update copy is busy is refused
      host_u.wr(`TCC_OFS_ISTAT, 32'hF);
      host_u.wr(`TCC_OFS_CMD, 32'h0800_0000);
      host_u.wr(`TCC_OFS_CMD, {7'h00, `TCC_CODE_VERSION, 16'h0000});
      repeat (70) @(posedge clk_sys);
      host_u.rd(`TCC_OFS_ISTAT, r);
      chk(r & 32'hA, 32'hA);
      $display("test interrupts done");
      conclude();
   end
endmodule : thermal_ctrl_command_set_bench

bind tcc_cmd tcc_cmd_asserts asrt_u (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
   .reg_rd, .reg_rdata, .irq, .fan_run_pin, .err_src_pin, .thermoelectric_mode,
   .heater_only_mode, .sensor_kind_sel, .integration_limit);
